/* verilog/sioi_top.sv */
// Run/stop control, forcing mode and indicator drive for a safe I/O module
`timescale 1ns/10ps
module sioi_top
	import sioi_pkg::*;
#(
	parameter int N_IN = 8,
	parameter int N_OUT = 4,
	parameter int TICK_CNT = TICK_CYCLES,
	parameter longint FORCE_WINDOW_TICKS = FORCE_WINDOW_S * TICKS_PER_S,
	parameter int FORCE_ERR_TICKS = FORCE_ERR_S * TICKS_PER_S
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins and monitors (asynchronous)
	input wire logic [N_IN-1:0] safe_input_pin,
	input wire logic supply_in_range,
	input wire logic supply_in_window,
	input wire logic config_verified,
	input wire logic config_invalid,
	input wire logic crit_err_own,
	input wire logic crit_err_other,
	input wire logic host_link_err,
	input wire logic [N_IN-1:0] input_err,
	input wire logic [N_IN-1:0] input_dual_err,
	input wire logic [N_IN/2-1:0] mat_pair,
	// Logic side
	input wire logic [N_OUT-1:0] logic_output_req,
	input wire logic [N_OUT-1:0] output_test_err,
	output logic [N_IN-1:0] logic_input_val,
	output logic first_cycle_bit,
	output logic fb_reset,
	output logic app_running,
	output logic [N_OUT-1:0] safe_output_drive,
	// Indicators
	output logic [1:0] module_state_indicator,
	output logic [N_IN-1:0] input_indicator,
	output logic [N_OUT-1:0] output_indicator,
	output logic config_verified_indicator
);
	localparam int NS = 10 + 2 * N_IN;
	localparam int TW = $clog2(TICK_CNT + 1);

	function automatic int popcount(input logic [N_IN-1:0] v);
		int c;
		c = 0;
		for (int i = 0; i < N_IN; i++) begin
			c += int'(v[i]);
		end
		return c;
	endfunction : popcount

	// Two-stage synchronisers for the pins, error flags and monitors; dual and mat flags bypass them
	logic [NS-1:0] sync1_ff, sync2_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {safe_input_pin, input_err, supply_in_range, supply_in_window, config_verified,
				config_invalid, crit_err_own, crit_err_other, host_link_err, |input_dual_err,
				|mat_pair, 1'b0};
			sync2_ff <= sync1_ff;
		end
	end
	logic [N_IN-1:0] pin_s, err_s;
	logic sup_ok, win_ok, verified_s, cfg_bad, crit_own, crit_oth, link_err;
	assign pin_s = sync2_ff[NS-1 -: N_IN];
	assign err_s = sync2_ff[NS-1-N_IN -: N_IN];
	assign sup_ok = sync2_ff[9];
	assign win_ok = sync2_ff[8];
	assign verified_s = sync2_ff[7];
	assign cfg_bad = sync2_ff[6];
	assign crit_own = sync2_ff[5];
	assign crit_oth = sync2_ff[4];
	assign link_err = sync2_ff[3];
	// Dual and mat flags are configuration-static, used directly
	logic [N_IN-1:0] dual_s;
	assign dual_s = input_dual_err;

	// Shared 4 Hz tick: one divider for every flash pattern
	logic [TW-1:0] tick_cnt_ff;
	logic tick;
	logic [1:0] phase_ff;
	assign tick = (tick_cnt_ff == TW'(TICK_CNT - 1));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= '0;
			phase_ff <= '0;
		end else if (tick) begin
			tick_cnt_ff <= '0;
			phase_ff <= phase_ff + 2'h1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + TW'(1);
		end
	end
	logic flash1, flash2;
	assign flash1 = phase_ff[1];
	assign flash2 = phase_ff[0];

	// APB decode; zero wait states
	logic wr_en;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	logic addr_ok;
	always_comb begin
		unique case (paddr)
			OFS_CTRL, OFS_STATUS, OFS_FORCE_EN, OFS_FORCE_VAL, OFS_FORCE_CMD: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_ok;
	logic cmd_start, cmd_stop, keepalive, f_enter, f_exit, f_rej;
	assign cmd_start = wr_en && paddr == OFS_CTRL && pwdata[CTRL_START];
	assign cmd_stop = wr_en && paddr == OFS_CTRL && pwdata[CTRL_STOP];
	assign keepalive = wr_en && paddr == OFS_CTRL && pwdata[CTRL_KEEPALIVE];
	assign f_enter = wr_en && paddr == OFS_FORCE_CMD && pwdata[FCMD_ENTER];
	assign f_exit = wr_en && paddr == OFS_FORCE_CMD && pwdata[FCMD_EXIT];
	assign f_rej = wr_en && paddr == OFS_FORCE_CMD && pwdata[FCMD_REJECT_OUT];

	// Forcing window since power-on
	logic [47:0] up_ticks_ff;
	logic win_open;
	assign win_open = up_ticks_ff < 48'(FORCE_WINDOW_TICKS);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_ticks_ff <= '0;
		end else if (tick && win_open) begin
			up_ticks_ff <= up_ticks_ff + 48'h1;
		end
	end

	// Forcing mode
	logic forcing_ff, reject_ff, force_end;
	logic [N_IN-1:0] force_en_ff, force_val_ff;
	logic [7:0] err_ticks_ff;
	logic critical;
	assign critical = crit_own || crit_oth;
	assign force_end = forcing_ff && (f_exit || critical || verified_s ||
		(link_err && err_ticks_ff >= 8'(FORCE_ERR_TICKS - 1) && tick));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			forcing_ff <= 1'b0;
		end else if (force_end) begin
			forcing_ff <= 1'b0;
		end else if (f_enter && win_open && !verified_s && !critical) begin
			forcing_ff <= 1'b1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			err_ticks_ff <= '0;
		end else if (!forcing_ff || !link_err) begin
			err_ticks_ff <= '0;
		end else if (tick) begin
			err_ticks_ff <= err_ticks_ff + 8'h1;
		end
	end
	logic force_en_too_many;
	assign force_en_too_many = popcount(pwdata[N_IN-1:0]) > FORCE_MAX_INPUTS;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			force_en_ff <= '0;
			force_val_ff <= '0;
		end else if (!forcing_ff) begin
			force_en_ff <= '0;
		end else if (wr_en && paddr == OFS_FORCE_EN && !force_en_too_many) begin
			force_en_ff <= pwdata[N_IN-1:0];
		end else if (wr_en && paddr == OFS_FORCE_VAL) begin
			force_val_ff <= pwdata[N_IN-1:0];
		end
	end
	// Sticky reject flag; refused enter and force-enable writes and the reject command set it, reading status clears
	logic rej_set, status_rd;
	assign status_rd = psel && penable && !pwrite && paddr == OFS_STATUS;
	assign rej_set = f_rej || (wr_en && paddr == OFS_FORCE_EN && (force_en_too_many || !forcing_ff)) ||
		(f_enter && !(win_open && !verified_s && !critical));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reject_ff <= 1'b0;
		end else if (rej_set) begin
			reject_ff <= 1'b1;
		end else if (status_rd) begin
			reject_ff <= 1'b0;
		end
	end
	always_comb begin
		for (int i = 0; i < N_IN; i++) begin
			logic_input_val[i] = force_en_ff[i] ? force_val_ff[i] : pin_s[i];
		end
	end

	// Run/stop state machine
	sioi_state_t state_ff;
	// Boot window waits out the synchroniser so the verified flag is valid
	logic [1:0] boot_cnt_ff;
	logic boot_check;
	logic go_run, go_stop;
	assign boot_check = boot_cnt_ff == 2'h2;
	assign go_stop = critical || force_end || cmd_stop;
	assign go_run = !critical && !cfg_bad && (cmd_start || f_enter && forcing_ff == 1'b0 &&
		win_open && !verified_s || (boot_check && verified_s));
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt_ff <= 2'h0;
		end else if (boot_cnt_ff != 2'h3) begin
			boot_cnt_ff <= boot_cnt_ff + 2'h1;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SIOI_STOP;
		end else begin
			unique case (state_ff)
				SIOI_STOP: if (go_run && !go_stop) state_ff <= SIOI_FIRST;
				SIOI_FIRST: state_ff <= go_stop ? SIOI_STOP : SIOI_RUN;
				SIOI_RUN: if (go_stop) state_ff <= SIOI_STOP;
			endcase
		end
	end
	assign first_cycle_bit = state_ff == SIOI_FIRST;
	assign fb_reset = state_ff == SIOI_STOP && go_run && !go_stop;
	assign app_running = state_ff != SIOI_STOP;

	// Outputs off while stopped or in critical error
	logic [N_OUT-1:0] out_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ff <= '0;
		end else if (go_stop || state_ff == SIOI_STOP) begin
			out_ff <= '0;
		end else begin
			out_ff <= logic_output_req;
		end
	end
	assign safe_output_drive = out_ff;

	// Indicators
	logic repairable;
	assign repairable = |err_s || |output_test_err;
	logic [1:0] ms_nxt, ms_ff;
	always_comb begin
		if (!sup_ok) begin
			ms_nxt = LED_OFF;
		end else if (crit_own) begin
			ms_nxt = flash2 ? LED_RED : LED_OFF;
		end else if (crit_oth) begin
			ms_nxt = LED_RED;
		end else if (cfg_bad) begin
			ms_nxt = flash1 ? LED_RED : LED_OFF;
		end else if (repairable) begin
			ms_nxt = flash1 ? LED_RED : LED_GREEN;
		end else if (state_ff == SIOI_STOP || !win_ok) begin
			ms_nxt = flash1 ? LED_GREEN : LED_OFF;
		end else begin
			ms_nxt = LED_GREEN;
		end
	end
	logic [N_IN-1:0] in_led;
	always_comb begin
		for (int i = 0; i < N_IN; i++) begin
			if (err_s[i] && pin_s[i]) begin
				in_led[i] = !flash1;
			end else if (dual_s[i] && !pin_s[i]) begin
				in_led[i] = flash1;
			end else if (mat_pair[i/2] && pin_s[i & ~1] && pin_s[i | 1]) begin
				in_led[i] = 1'b0;
			end else begin
				in_led[i] = pin_s[i];
			end
		end
	end
	logic [N_OUT-1:0] out_led;
	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			out_led[i] = output_test_err[i] ? flash1 : out_ff[i];
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_ff <= LED_OFF;
			input_indicator <= '0;
			output_indicator <= '0;
			config_verified_indicator <= 1'b0;
		end else begin
			ms_ff <= ms_nxt;
			input_indicator <= in_led;
			output_indicator <= out_led;
			config_verified_indicator <= verified_s || flash1;
		end
	end
	assign module_state_indicator = ms_ff;

	// Read data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_STATUS: prdata <= 32'({reject_ff, win_open, forcing_ff, first_cycle_bit, app_running} |
					(32'(verified_s) << ST_VERIFIED));
				OFS_FORCE_EN: prdata <= 32'(force_en_ff);
				OFS_FORCE_VAL: prdata <= 32'(force_val_ff);
				default: prdata <= '0;
			endcase
		end
	end
endmodule : sioi_top

/* verilog/sioi_pkg.sv */
// Package of constants for the safety I/O state and indicator block
package sioi_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int FLASH_2HZ_TOGGLE_HZ = 4;
	localparam int TICK_CYCLES = CLK_HZ / FLASH_2HZ_TOGGLE_HZ;
	localparam int FORCE_WINDOW_HOURS = 18;
	localparam longint FORCE_WINDOW_S = longint'(FORCE_WINDOW_HOURS) * 3600;
	localparam int FORCE_ERR_S = 3;
	localparam int FORCE_MAX_INPUTS = 10;
	localparam int TICKS_PER_S = FLASH_2HZ_TOGGLE_HZ;
	// Indicator colour codes, {red, green}
	localparam logic [1:0] LED_OFF = 2'h0;
	localparam logic [1:0] LED_GREEN = 2'h1;
	localparam logic [1:0] LED_RED = 2'h2;
	// APB register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FORCE_EN = 8'h08;
	localparam logic [7:0] OFS_FORCE_VAL = 8'h0C;
	localparam logic [7:0] OFS_FORCE_CMD = 8'h10;
	// CTRL bits (write-one pulses)
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_KEEPALIVE = 2;
	// FORCE_CMD bits (write-one pulses)
	localparam int FCMD_ENTER = 0;
	localparam int FCMD_EXIT = 1;
	localparam int FCMD_REJECT_OUT = 2;
	// STATUS bit positions
	localparam int ST_RUN = 0;
	localparam int ST_FIRST = 1;
	localparam int ST_FORCING = 2;
	localparam int ST_WIN_OPEN = 3;
	localparam int ST_REJECT = 4;
	localparam int ST_VERIFIED = 5;
	typedef enum logic [1:0] {SIOI_STOP, SIOI_FIRST, SIOI_RUN} sioi_state_t;
endpackage : sioi_pkg

/* bench/sioi_props.sv */
// Port assertions for the safety I/O state and indicator block
`timescale 1ns/10ps
module sioi_props
	import sioi_pkg::*;
#(
	parameter int N_IN = 8,
	parameter int N_OUT = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Monitors and pins
	input wire logic [N_IN-1:0] safe_input_pin,
	input wire logic supply_in_range,
	input wire logic supply_in_window,
	input wire logic config_invalid,
	input wire logic crit_err_own,
	input wire logic crit_err_other,
	input wire logic [N_IN-1:0] input_err,
	input wire logic [N_IN-1:0] input_dual_err,
	input wire logic [N_IN/2-1:0] mat_pair,
	input wire logic [N_OUT-1:0] output_test_err,
	// Design outputs
	input wire logic first_cycle_bit,
	input wire logic fb_reset,
	input wire logic app_running,
	input wire logic [N_OUT-1:0] safe_output_drive,
	input wire logic [1:0] module_state_indicator,
	input wire logic [N_IN-1:0] input_indicator,
	input wire logic [N_OUT-1:0] output_indicator
);
	logic calm;
	// Calm: supply in range and window, configuration valid, no critical error
	assign calm = supply_in_range && supply_in_window && !config_invalid && !crit_err_own && !crit_err_other;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_DARK: assert property ((!supply_in_range && !crit_err_own && !crit_err_other) [*6] |-> module_state_indicator == LED_OFF)
		else $error("state indicator lit with bad supply");
	AST_HALT: assert property ((crit_err_own || crit_err_other) [*6] |-> !app_running && safe_output_drive == '0)
		else $error("critical error left outputs on");
	AST_RED: assert property ((crit_err_other && !crit_err_own && supply_in_range) [*6] |-> module_state_indicator == LED_RED)
		else $error("no steady red on remote critical error");
	AST_FIRST: assert property (fb_reset |=> first_cycle_bit && !fb_reset ##1 !first_cycle_bit)
		else $error("first cycle bit not a single cycle");
	AST_OUT_DARK: assert property ((!safe_output_drive[0] && !output_test_err[0]) [*3] |-> !output_indicator[0])
		else $error("output indicator lit while off");
	AST_OUT_SYNC: assert property ((output_test_err[0] && calm) [*6] |-> output_indicator[0] == module_state_indicator[1])
		else $error("output flash out of phase");
	AST_IN_DARK: assert property ((!safe_input_pin[0] && !input_err[0] && !input_dual_err[0] && !mat_pair[0]) [*6] |-> !input_indicator[0])
		else $error("input indicator lit at low input");
	AST_IN_LIT: assert property ((safe_input_pin[0] && !input_err[0] && !input_dual_err[0] && !mat_pair[0]) [*6] |-> input_indicator[0])
		else $error("input indicator dark at high input");
	AST_IN_ANTI: assert property ((safe_input_pin[0] && input_err[0] && calm) [*6] |-> input_indicator[0] != module_state_indicator[1])
		else $error("input flash not in antiphase");
endmodule : sioi_props
bind sioi_top sioi_props #(.N_IN(N_IN), .N_OUT(N_OUT)) sioi_props_inst (.*);

/* bench/sioi_host.sv */
// Host-side bus model that issues register transfers
`timescale 1ns/10ps
module sioi_host (
	// Clock and answer
	input wire logic core_clk,
	input wire logic pready,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
	end
	// Start, stop and force commands all pass here; released address and data lines carry inverted stale values
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output bit ok);
		int n;
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		ok = (pready === 1'b1);
		{psel, penable, paddr, pwdata} <= {1'b0, 1'b0, ~a, ~d};
	endtask : xfer
endmodule : sioi_host

/* bench/sioi_top_tb.sv */
// Self-checking testbench of the safety I/O state and indicator block
`timescale 1ns/10ps
module sioi_top_tb
	import sioi_pkg::*;
;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, config_verified_indicator;
	logic [7:0] paddr, safe_input_pin, input_err, input_dual_err, logic_input_val, input_indicator;
	logic [31:0] pwdata, prdata, seed, exp_q[$], msk_q[$];
	logic supply_in_range, supply_in_window, config_verified, config_invalid;
	logic crit_err_own, crit_err_other, host_link_err, first_cycle_bit, fb_reset, app_running;
	logic [3:0] mat_pair, logic_output_req, output_test_err, safe_output_drive, output_indicator;
	logic [1:0] module_state_indicator;
	int fails = 0;
	int total_checks = 0;
	sioi_top #(.TICK_CNT(4), .FORCE_WINDOW_TICKS(50), .FORCE_ERR_TICKS(3)) sioi_top_inst (.*);
	sioi_host sioi_host_inst (.*);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task ed(input int n);
		repeat (n) @(posedge core_clk);
	endtask : ed
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit ok;
		sioi_host_inst.xfer(w, a, d, ok);
		if (!ok) begin
			fails++;
			complete_run();
		end
	endtask : bus
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		msk_q.push_back(m);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Counts lit cycles over one full 1 Hz period, after the input synchronisers settle
	task cnt(input string n, input int s, input int e);
		logic [31:0] c;
		c = 0;
		ed(6);
		repeat (16) begin
			@(negedge core_clk);
			case (s)
				0: c += module_state_indicator[0];
				1: c += module_state_indicator[1];
				2: c += input_indicator[0];
				default: c += output_indicator[0];
			endcase
		end
		chk(n, e, c);
		ed(1);
	endtask : cnt
	task rst(input logic cv);
		ed(1);
		config_verified <= cv;
		rst_n <= 1'b0;
		ed(3);
		rst_n <= 1'b1;
	endtask : rst
	always @(posedge core_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			chk("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());
		end
	end
	initial begin
		ed(100000);
		fails++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		seed = 32'hF792;
		rst_n = 1'b0;
		{safe_input_pin, input_err, input_dual_err, mat_pair, logic_output_req, output_test_err} = '0;
		{config_verified, config_invalid, crit_err_own, crit_err_other, host_link_err} = '0;
		{supply_in_range, supply_in_window} = 2'h3;
		ed(3);
		rst_n <= 1'b1;
		ed(20);
		chk("running", 32'h0, 32'(app_running));
		cnt("ms_green", 0, 8);
		rd(OFS_STATUS, 32'h1, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		rd(OFS_STATUS, 32'h1, 32'h1);
		cnt("ms_green", 0, 16);
		repeat (6) begin
			r = xs();
			safe_input_pin <= r[7:0];
			logic_output_req <= r[11:8];
			ed(5);
			@(negedge core_clk);
			chk("logic_in", 32'(safe_input_pin), 32'(logic_input_val));
			chk("in_led", 32'(safe_input_pin), 32'(input_indicator));
			chk("drive", 32'(logic_output_req), 32'(safe_output_drive));
			ed(1);
		end
		{safe_input_pin, input_err, logic_output_req, output_test_err} <= {8'h01, 8'h01, 4'h0, 4'h0};
		cnt("in_flash", 2, 8);
		cnt("ms_red", 1, 8);
		{input_err, output_test_err} <= {8'h00, 4'h1};
		cnt("out_flash", 3, 8);
		output_test_err <= 4'h0;
		cnt("out_dark", 3, 0);
		bus(1'b1, OFS_CTRL, 32'h2);
		rd(OFS_STATUS, 32'h1, 32'h0);
		supply_in_range <= 1'b0;
		cnt("ms_dark", 0, 0);
		cnt("ms_dark", 1, 0);
		supply_in_range <= 1'b1;
		$display("test indicators done");
		rst(1'b0);
		bus(1'b1, OFS_FORCE_CMD, 32'h1);
		rd(OFS_STATUS, 32'h5, 32'h5);
		safe_input_pin <= 8'h00;
		bus(1'b1, OFS_FORCE_EN, 32'h1);
		bus(1'b1, OFS_FORCE_VAL, 32'h1);
		ed(4);
		@(negedge core_clk);
		chk("forced", 32'h1, 32'(logic_input_val[0]));
		bus(1'b1, OFS_FORCE_CMD, 32'h4);
		rd(OFS_STATUS, 32'h10, 32'h10);
		rd(OFS_STATUS, 32'h10, 32'h0);
		host_link_err <= 1'b1;
		ed(30);
		@(negedge core_clk);
		chk("ended", 32'h0, 32'({app_running, safe_output_drive}));
		rd(OFS_STATUS, 32'h4, 32'h0);
		host_link_err <= 1'b0;
		ed(250);
		bus(1'b1, OFS_FORCE_CMD, 32'h1);
		rd(OFS_STATUS, 32'h5, 32'h0);
		rd(8'h20, 32'hFFFFFFFF, 32'h0);
		$display("test forcing done");
		crit_err_other <= 1'b1;
		cnt("ms_red", 1, 16);
		chk("running", 32'h0, 32'(app_running));
		crit_err_other <= 1'b0;
		rst(1'b1);
		ed(10);
		chk("autorun", 32'h1, 32'(app_running));
		bus(1'b1, OFS_FORCE_CMD, 32'h1);
		rd(OFS_STATUS, 32'h4, 32'h0);
		crit_err_own <= 1'b1;
		cnt("ms_red", 1, 8);
		chk("drive", 32'h0, 32'(safe_output_drive));
		$display("test critical done");
		complete_run();
	end
endmodule : sioi_top_tb
